// File: hw/led_string_fault_supervisor.sv
// Purpose: startup, boost switch, dimming and string fault sequencer
// Assumes: comparator inputs are asynchronous levels from the analog core
// Notes:   lowest-channel selection itself is analog, steered by fb_mask_o
//
// Functional notes
// - on enable, overvoltage sense below 75mV keeps the device disabled
// - lockout and overtemperature are checked only after the sense check passes
// - all checks passed starts switching through soft-start
// - stay disabled while regulator rail is below lockout; comparator has hysteresis
// - switch turns on each cycle start and stays on at least 100ns
// - switch turns off when sensed current reaches error amplifier level
// - light load skips pulses until the loop demands boosting again
// - regulate on lowest active channel; marked channels excluded
// - two dimming modes: external pulse or internal pulse from DC level
// - strings conduct only during the active dimming phase
// - at overvoltage trip, channels below 196mV are marked open, removed
// - keep one string lit; all marked open stops switching
// - open marks hold until enable is dropped or reset
// - channel above 6.1V flags a short
// - short lasting 4096 switching clocks marks channel off, sink disabled
// - short-marked string leaves feedback and stays off until restart
// - all strings short-marked stops switching
// - overtemperature shuts down until enable is cycled
`timescale 1ns/100ps
`default_nettype none
module led_string_fault_supervisor
  import led_sup_pkg::*;
#(
  parameter int N          = NUM_STRINGS,
  parameter int SW_PERIOD  = SW_PERIOD_CYC,
  parameter int PERSIST    = SHORT_PERSIST_CLKS
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         enable_i,
  input  wire logic         ovp_sense_low_i,
  input  wire logic         ovp_trip_i,
  input  wire logic         supply_undervoltage_lockout_ok_i,
  input  wire logic         overtemp_i,
  input  wire logic         boost_demand_i,
  input  wire logic         pwm_cmp_i,
  input  wire logic         dim_mode_dc_i,
  input  wire logic         brightness_input_i,
  input  wire logic         dim_cmp_i,
  input  wire logic [N-1:0] chan_low_i,
  input  wire logic [N-1:0] chan_over_i,
  output logic              gate_o,
  output logic [N-1:0]      sink_en_o,
  output logic [N-1:0]      open_mark_o,
  output logic [N-1:0]      short_mark_o,
  output logic [N-1:0]      fb_mask_o,
  output logic              running_o,
  output logic              shutdown_o
);
  localparam int MAX_ON = SW_PERIOD - MIN_OFF_CYC;
  localparam int SYN_W  = 10 + 2 * N;

  // ***************************************************
  // input synchronisers
  // ***************************************************
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic [SYN_W-1:0] next_sync1;

  always_comb begin
    next_sync1 = {enable_i, ovp_sense_low_i, ovp_trip_i, supply_undervoltage_lockout_ok_i, overtemp_i,
                  boost_demand_i, pwm_cmp_i, dim_mode_dc_i, brightness_input_i,
                  dim_cmp_i, chan_low_i, chan_over_i};
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end

  logic         en_s;
  logic         ovp_low_s;
  logic         ovp_trip_s;
  logic         supply_undervoltage_lockout_ok_s;
  logic         otp_s;
  logic         demand_s;
  logic         pwm_cmp_s;
  logic         dim_dc_s;
  logic         bright_s;
  logic         dim_cmp_s;
  logic [N-1:0] low_s;
  logic [N-1:0] over_s;

  assign {en_s, ovp_low_s, ovp_trip_s, supply_undervoltage_lockout_ok_s, otp_s, demand_s, pwm_cmp_s,
          dim_dc_s, bright_s, dim_cmp_s, low_s, over_s} = sync2;

  // ***************************************************
  // switching clock divider
  // ***************************************************
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] next_per_cnt;
  logic             sw_tick;

  always_comb begin
    if (per_cnt == CNT_W'(SW_PERIOD - 1)) begin
      next_per_cnt = CNT_RESET;
    end else begin
      next_per_cnt = per_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      per_cnt <= CNT_RESET;
    end else begin
      per_cnt <= next_per_cnt;
    end
  end

  assign sw_tick = (per_cnt == CNT_RESET);

  // ***************************************************
  // short persistence channels
  // ***************************************************
  logic [N-1:0] short_marks;
  logic [N-1:0] all_marks;
  logic         all_off;
  logic         clear_marks;
  sup_state_e   state;

  assign clear_marks = (state == ST_OFF);

  for (genvar g = 0; g < N; g++) begin : g_chan
    short_chan_if sif ();
    assign sif.over  = over_s[g];
    assign sif.tick  = sw_tick;
    assign sif.clear = clear_marks;
    assign short_marks[g] = sif.marked;
    short_persist #(.PERSIST(PERSIST)) u_persist (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .sc       (sif.chan)
    );
  end

  assign short_mark_o = short_marks;
  assign all_marks    = open_mark_o | short_marks;
  assign all_off      = &all_marks;

  // ***************************************************
  // startup and protection sequencer
  // ***************************************************
  sup_state_e       next_state;
  logic [CNT_W-1:0] ss_cap;
  logic [CNT_W-1:0] next_ss_cap;
  logic             sw_now;

  assign sw_now = (state == ST_SOFT) || (state == ST_RUN);

  always_comb begin
    next_state  = state;
    next_ss_cap = ss_cap;
    case (state)
      ST_OFF: begin
        if (en_s) begin
          next_state = ST_CHK_OVP;
        end
      end
      ST_CHK_OVP: begin
        if (ovp_low_s) begin
          next_state = ST_SHUT;
        end else begin
          next_state = ST_CHK_PROT;
        end
      end
      ST_CHK_PROT: begin
        if (otp_s) begin
          next_state = ST_SHUT;
        end else if (supply_undervoltage_lockout_ok_s) begin
          next_state  = ST_SOFT;
          next_ss_cap = CNT_W'(MIN_ON_CYC);
        end
      end
      ST_SOFT, ST_RUN: begin
        if (otp_s) begin
          next_state = ST_SHUT;
        end else if (!supply_undervoltage_lockout_ok_s) begin
          next_state = ST_CHK_PROT;
        end else if (state == ST_SOFT && sw_tick) begin
          if (ss_cap >= CNT_W'(MAX_ON - SS_STEP_CYC)) begin
            next_state = ST_RUN;
          end else begin
            next_ss_cap = ss_cap + CNT_W'(SS_STEP_CYC);
          end
        end
      end
      ST_SHUT: begin
        next_state = ST_SHUT;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!en_s) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state  <= ST_OFF;
      ss_cap <= CNT_RESET;
    end else begin
      state  <= next_state;
      ss_cap <= next_ss_cap;
    end
  end

  // ***************************************************
  // boost switch on-time control
  // ***************************************************
  logic             next_gate;
  logic [CNT_W-1:0] on_cnt;
  logic [CNT_W-1:0] next_on_cnt;
  logic [CNT_W-1:0] on_cap;

  assign on_cap = (state == ST_SOFT) ? ss_cap : CNT_W'(MAX_ON);

  always_comb begin
    next_gate   = gate_o;
    next_on_cnt = on_cnt;
    if (!sw_now || all_off) begin
      next_gate   = 1'b0;
      next_on_cnt = CNT_RESET;
    end else if (gate_o) begin
      next_on_cnt = on_cnt + 1'b1;
      if (on_cnt >= CNT_W'(MIN_ON_CYC)) begin
        if (pwm_cmp_s || on_cnt >= on_cap) begin
          next_gate = 1'b0;
        end
      end
    end else if (sw_tick && demand_s) begin
      next_gate   = 1'b1;
      next_on_cnt = 16'h0001;
    end
    // no demand at cycle start: pulse skipped
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gate_o <= 1'b0;
      on_cnt <= CNT_RESET;
    end else begin
      gate_o <= next_gate;
      on_cnt <= next_on_cnt;
    end
  end

  // ***************************************************
  // string marks, dimming and sinks
  // ***************************************************
  logic         dim_active;
  logic [N-1:0] next_open;
  logic [N-1:0] next_sink;
  logic [N-1:0] next_fb;

  assign dim_active = dim_dc_s ? dim_cmp_s : bright_s;

  always_comb begin
    next_open = open_mark_o;
    if (clear_marks) begin
      next_open = '0;
    end else if (sw_now && ovp_trip_s) begin
      next_open = open_mark_o | (low_s & ~short_marks);
    end
    next_fb   = ~all_marks;
    next_sink = {N{sw_now & dim_active}} & ~all_marks;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      open_mark_o <= '0;
      sink_en_o   <= '0;
      fb_mask_o   <= '0;
      running_o   <= 1'b0;
      shutdown_o  <= 1'b0;
    end else begin
      open_mark_o <= next_open;
      sink_en_o   <= next_sink;
      fb_mask_o   <= next_fb;
      running_o   <= sw_now & ~all_off;
      shutdown_o  <= (state == ST_SHUT);
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_ovp_low_halts: assert property (
    state == ST_CHK_OVP && ovp_low_s && en_s |=> state == ST_SHUT)
    else $error("low overvoltage sense did not halt startup");
  a_prot_after_ovp: assert property (
    state == ST_CHK_PROT && $past(state) != ST_CHK_PROT |-> $past(state) == ST_CHK_OVP
      || $past(state) == ST_SOFT || $past(state) == ST_RUN)
    else $error("protection check entered out of order");
  a_soft_entry: assert property (
    state == ST_SOFT && $past(state) != ST_SOFT |-> $past(state) == ST_CHK_PROT)
    else $error("soft-start entered without checks");
  a_supply_undervoltage_lockout_stops: assert property (
    sw_now && !supply_undervoltage_lockout_ok_s && en_s && !otp_s |=> state == ST_CHK_PROT ##1 !gate_o)
    else $error("switching continued below lockout");
  a_min_on_time: assert property (
    $fell(gate_o) && $past(sw_now) && sw_now && !$past(all_off)
      |-> $past(on_cnt) >= MIN_ON_CYC)
    else $error("gate on-time shorter than minimum");
  a_cmp_turns_off: assert property (
    gate_o && sw_now && on_cnt >= MIN_ON_CYC && pwm_cmp_s |=> !gate_o)
    else $error("gate not turned off at comparator trip");
  a_skip_pulse: assert property (
    sw_tick && !demand_s && !gate_o |=> !gate_o)
    else $error("pulse issued without demand");
  a_fb_excludes: assert property (
    1'b1 |=> (fb_mask_o & $past(all_marks)) == '0)
    else $error("marked channel left in feedback");
  a_dim_gates_sink: assert property (
    !dim_active |=> sink_en_o == '0)
    else $error("sink on outside dimming phase");
  a_open_marking: assert property (
    sw_now && ovp_trip_s && en_s |=> (open_mark_o & $past(low_s & ~short_marks))
      == $past(low_s & ~short_marks))
    else $error("low channel not marked open");
  a_all_off_stop: assert property (
    all_off && $past(all_off) |-> !gate_o)
    else $error("switching with every string marked");
  a_open_held: assert property (
    $past(state) != ST_OFF |-> ($past(open_mark_o) & ~open_mark_o) == '0)
    else $error("open mark cleared while enabled");
  a_short_sink_off: assert property (
    1'b1 |=> (sink_en_o & $past(short_marks)) == '0)
    else $error("short-marked sink still enabled");
  a_otp_latched: assert property (
    state == ST_SHUT && en_s |=> state == ST_SHUT)
    else $error("shutdown released without enable cycle");
endmodule
`default_nettype wire

// File: hw/short_persist.sv
// Purpose: per-string short-fault persistence counter and mark
// Assumes: tick is a one-cycle pulse per switching clock
// Notes:   mark is sticky until clear
`timescale 1ns/100ps
`default_nettype none
module short_persist
  import led_sup_pkg::*;
#(
  parameter int PERSIST = SHORT_PERSIST_CLKS
) (
  input wire logic   clk_i,
  input wire logic   resetn_i,
  short_chan_if.chan sc
);
  localparam int W = $clog2(PERSIST + 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         marked;
  logic         next_marked;

  // ***************************************************
  // persistence count
  // ***************************************************
  always_comb begin
    next_count  = count;
    next_marked = marked;
    if (sc.clear) begin
      next_count  = '0;
      next_marked = 1'b0;
    end else if (!sc.over) begin
      next_count = '0;
    end else if (sc.tick && !marked) begin
      if (count == W'(PERSIST - 1)) begin
        next_marked = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      count  <= '0;
      marked <= 1'b0;
    end else begin
      count  <= next_count;
      marked <= next_marked;
    end
  end

  assign sc.marked = marked;
endmodule
`default_nettype wire

// File: shared/led_sup_pkg.sv
// Purpose: shared constants and types for the led string supervisor
// Assumes: 125 MHz system clock
// Notes:   minimum on-time is kept in ns and converted; other times are given in cycles
package led_sup_pkg;
  localparam int NUM_STRINGS        = 4;
  localparam int CLK_MHZ            = 125;
  localparam int MIN_ON_NS          = 100;
  // least time, rounded up to whole cycles
  localparam int MIN_ON_CYC         = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  // default switching period: 185 kHz at 125 MHz
  localparam int SW_PERIOD_CYC      = 676;
  localparam int MIN_OFF_CYC        = 25;
  localparam int SS_STEP_CYC        = 2;
  localparam int SHORT_PERSIST_CLKS = 4096;
  localparam int CNT_W              = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam int SYNC_W             = 10 + 2 * NUM_STRINGS;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CHK_OVP,
    ST_CHK_PROT,
    ST_SOFT,
    ST_RUN,
    ST_SHUT
  } sup_state_e;
endpackage

// File: shared/short_chan_if.sv
// Purpose: carrier between the supervisor and one short-persistence counter
// Assumes: all signals on the supervisor clock
// Notes:   one instance per string
`timescale 1ns/100ps
`default_nettype none
interface short_chan_if;
  logic over;
  logic tick;
  logic clear;
  logic marked;
  modport ctrl (output over, output tick, output clear, input marked);
  modport chan (input over, input tick, input clear, output marked);
endinterface
`default_nettype wire

// File: tb/led_load_model.sv
// Purpose: boost stage and four led strings seen from the supervisor
// Assumes: one clock domain, comparator levels change after the clock edge
// Notes:   an open string pulls its channel low and the output climbs to overvoltage
`timescale 1ns/100ps
`default_nettype none
module led_load_model (
  input  wire logic       clk_i,
  input  wire logic       gate_i,
  input  wire logic [7:0] ramp_len_i,
  input  wire logic [3:0] open_cfg_i,
  input  wire logic [3:0] short_cfg_i,
  input  wire logic [3:0] open_mark_i,
  output logic            pwm_cmp_o,
  output logic            ovp_trip_o,
  output logic [3:0]      chan_low_o,
  output logic [3:0]      chan_over_o
);
  logic [7:0] ramp;
  logic [3:0] volt;
  logic       gate_d;
  initial begin
    ramp   = 8'h00;
    volt   = 4'h0;
    gate_d = 1'b0;
  end
  // inductor ramp while on, output climbs per pulse while an unmarked string is open
  always @(posedge clk_i) begin
    gate_d <= gate_i;
    ramp   <= gate_i ? ramp + 8'h01 : 8'h00;
    if ((open_cfg_i & ~open_mark_i) == 4'h0) begin
      volt <= 4'h0;
    end else if (gate_i & ~gate_d & (volt != 4'hf)) begin
      volt <= volt + 4'h1;
    end
  end
  assign pwm_cmp_o   = gate_i & (ramp >= ramp_len_i);
  assign ovp_trip_o  = volt >= 4'h3;
  assign chan_low_o  = open_cfg_i;
  assign chan_over_o = short_cfg_i;
endmodule
`default_nettype wire

// File: tb/led_string_fault_supervisor_bench.sv
// Purpose: self-checking bench for the led string supervisor
// Assumes: shortened switching period and persistence count
// Notes:   seed fixed at 95, load model drives the current, overvoltage-trip and channel comparator inputs
`timescale 1ns/100ps
`default_nettype none
module led_string_fault_supervisor_bench;
  import led_sup_pkg::*;
  localparam int SWP = 40;
  localparam int PER = 4;
  logic       clk_i = 1'b0;
  logic       resetn, enable, ovp_low, supply_undervoltage_lockout_ok, overtemp, demand, mode, bright, dcmp;
  logic       gate_o, running_o, shutdown_o, pwm_cmp, ovp_trip;
  logic [3:0] sink_en_o, open_mark_o, short_mark_o, fb_mask_o, chan_low, chan_over;
  logic [3:0] open_cfg, short_cfg, status;
  logic [7:0] ramp_len;
  int         errors, n_tests, cycles, seed, w, i;
  assign status = {2'b00, running_o, shutdown_o};
  always #4 clk_i = ~clk_i;
  led_string_fault_supervisor #(.N(4), .SW_PERIOD(SWP), .PERSIST(PER))
    i_led_string_fault_supervisor (
    .clk_i(clk_i), .resetn_i(resetn), .enable_i(enable), .ovp_sense_low_i(ovp_low),
    .ovp_trip_i(ovp_trip), .supply_undervoltage_lockout_ok_i(supply_undervoltage_lockout_ok), .overtemp_i(overtemp), .boost_demand_i(demand),
    .pwm_cmp_i(pwm_cmp), .dim_mode_dc_i(mode), .brightness_input_i(bright), .dim_cmp_i(dcmp),
    .chan_low_i(chan_low), .chan_over_i(chan_over), .gate_o(gate_o), .sink_en_o(sink_en_o),
    .open_mark_o(open_mark_o), .short_mark_o(short_mark_o), .fb_mask_o(fb_mask_o),
    .running_o(running_o), .shutdown_o(shutdown_o));
  led_load_model i_led_load_model (
    .clk_i(clk_i), .gate_i(gate_o), .ramp_len_i(ramp_len), .open_cfg_i(open_cfg),
    .short_cfg_i(short_cfg), .open_mark_i(open_mark_o), .pwm_cmp_o(pwm_cmp),
    .ovp_trip_o(ovp_trip), .chan_low_o(chan_low), .chan_over_o(chan_over));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic restart();
    enable <= 1'b0;
    cyc(6);
    enable <= 1'b1;
    for (int k = 0; k < 300 && running_o !== 1'b1; k++) begin
      cyc(1);
    end
  endtask
  task automatic gate_width(output int wd);
    for (int k = 0; k < 200 && gate_o !== 1'b1; k++) begin
      cyc(1);
    end
    wd = 0;
    while (gate_o === 1'b1 && wd < 200) begin
      cyc(1);
      wd++;
    end
  endtask
  function automatic logic [3:0] exp_sink(logic md, logic br, logic dc, logic [3:0] marks);
    return {4{md ? dc : br}} & ~marks;
  endfunction
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 95;
    {errors, n_tests, cycles} = 0;
    {resetn, enable, ovp_low, overtemp, mode, dcmp} = 6'h00;
    {supply_undervoltage_lockout_ok, demand, bright} = 3'h7;
    {open_cfg, short_cfg} = 8'h00;
    ramp_len = 8'h00;
    cyc(3);
    resetn <= 1'b1;
    ovp_low <= 1'b1;
    cyc(2);
    enable <= 1'b1;
    cyc(12);
    chk("sense low shutdown", 4'h1, status);
    ovp_low <= 1'b0;
    cyc(12);
    chk("sense low held", 4'h1, status);
    overtemp <= 1'b1;
    enable <= 1'b0;
    cyc(6);
    enable <= 1'b1;
    cyc(12);
    chk("overtemp at start", 4'h1, status);
    overtemp <= 1'b0;
    supply_undervoltage_lockout_ok <= 1'b0;
    enable <= 1'b0;
    cyc(6);
    enable <= 1'b1;
    cyc(3 * SWP);
    chk("lockout holds off", 4'h0, {3'b000, gate_o | running_o});
    supply_undervoltage_lockout_ok <= 1'b1;
    cyc(300);
    chk("soft start runs", 4'h2, status);
    gate_width(w);
    chk("min on time", 4'h1, {3'b000, w >= MIN_ON_CYC && w <= MIN_ON_CYC + 4});
    ramp_len <= 8'hc8;
    gate_width(w);
    chk("on time capped", 4'h1, {3'b000, w <= SWP - MIN_OFF_CYC + 3});
    ramp_len <= 8'h00;
    demand <= 1'b0;
    cyc(SWP);
    w = 0;
    for (i = 0; i < 3 * SWP; i++) begin
      cyc(1);
      w += int'(gate_o === 1'b1);
    end
    chk("pulses skipped", 4'h0, {3'b000, w != 0});
    demand <= 1'b1;
    gate_width(w);
    chk("pulse resumes", 4'h1, {3'b000, w > 0});
    for (i = 0; i < 10; i++) begin
      mode <= i[0];
      bright <= $random(seed);
      dcmp <= $random(seed);
      cyc(6);
      chk("dim sinks", exp_sink(mode, bright, dcmp, 4'h0), sink_en_o);
    end
    {mode, bright} <= 2'b01;
    open_cfg <= 4'h2;
    cyc(8 * SWP);
    chk("open mark", 4'h2, open_mark_o);
    chk("open feedback", 4'hd, fb_mask_o);
    chk("open sinks", 4'hd, sink_en_o);
    open_cfg <= 4'hf;
    cyc(8 * SWP);
    chk("all open", 4'h0, {open_mark_o != 4'hf, 1'b0, running_o, gate_o});
    open_cfg <= 4'h0;
    restart();
    chk("marks cleared", 4'h0, open_mark_o);
    short_cfg <= 4'h4;
    cyc((PER - 2) * SWP);
    short_cfg <= 4'h0;
    cyc(2 * SWP);
    chk("short dropped", 4'h0, short_mark_o);
    short_cfg <= 4'h4;
    cyc((PER - 2) * SWP);
    short_cfg <= 4'h0;
    cyc(2 * SWP);
    chk("short restarted", 4'h0, short_mark_o);
    short_cfg <= 4'h4;
    cyc((PER + 2) * SWP);
    short_cfg <= 4'h0;
    cyc(SWP);
    chk("short mark", 4'h4, short_mark_o);
    chk("short sinks", 4'hb, sink_en_o);
    chk("short feedback", 4'hb, fb_mask_o);
    short_cfg <= 4'hf;
    cyc((PER + 2) * SWP);
    chk("all short", 4'h0, {short_mark_o != 4'hf, 1'b0, running_o, gate_o});
    short_cfg <= 4'h0;
    restart();
    overtemp <= 1'b1;
    cyc(6);
    overtemp <= 1'b0;
    cyc(12);
    chk("thermal latch", 4'h1, {status[3:1] | {2'b00, gate_o}, status[0]});
    restart();
    chk("enable cycled", 4'h2, status);
    supply_undervoltage_lockout_ok <= 1'b0;
    cyc(6);
    chk("lockout in run", 4'h0, {2'b00, running_o, gate_o});
    supply_undervoltage_lockout_ok <= 1'b1;
    stop_test();
  end
endmodule
`default_nettype wire
